/* File: rtl/pcgc_params.svh */
// Offsets, field positions, masks and reset values of the clock gating control
`ifndef PCGC_PARAMS_SVH
`define PCGC_PARAMS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define PCGC_IDX_RATE 5'h0B
`define PCGC_IDX_PCE0 5'h0C
`define PCGC_IDX_PCE1 5'h0D
`define PCGC_IDX_SD0 5'h0E
`define PCGC_IDX_SD1 5'h0F
`define PCGC_IDX_CTRL 5'h10
`define PCGC_IDX_STAT 5'h11

// ==========================================================
// Writable-bit masks; reserved bits stay zero
`define PCGC_MASK_RATE 16'h7000
`define PCGC_MASK_GRP0 16'hF455
`define PCGC_MASK_GRP1 16'h700F

// ==========================================================
// Reset values
`define PCGC_RST_REG 16'h0000

// ==========================================================
// Field positions
`define PCGC_BIT_TMR_RATE 14
`define PCGC_BIT_PWM_RATE 13
`define PCGC_BIT_I2C_RATE 12
`define PCGC_BIT_GRP0_PWM 0
`define PCGC_BIT_GRP0_I2C 6
`define PCGC_BIT_GRP1_TMR_TOP 3
`define PCGC_BIT_CTRL_STOP 0
`define PCGC_BIT_STAT_STOP 0
`define PCGC_BIT_STAT_PLL 1

`endif

/* File: rtl/pcgc_pkg.sv */
// Types shared by both ends of the clock gating control
package pcgc_pkg;
  // ==========================================================
  // Power mode of the system, one-hot
  typedef enum logic [1:0] {
    PCGC_RUN = 2'b01,
    PCGC_STOP = 2'b10
  } pcgc_mode_t;

  // Clock source that feeds one gated peripheral clock
  typedef enum logic [1:0] {
    PCGC_SRC_SYS = 2'h0,
    PCGC_SRC_TMR = 2'h1,
    PCGC_SRC_PWM = 2'h2,
    PCGC_SRC_I2C = 2'h3
  } pcgc_src_t;
endpackage

/* File: rtl/pcgc_if.sv */
// Connection between the clock control and the peripherals it clocks
interface pcgc_if;
  logic [15:0] clk_g0; // Gated clocks, first group
  logic [15:0] clk_g1; // Gated clocks, second group
  logic [15:0] run0; // Clock running, first group
  logic [15:0] run1; // Clock running, second group
  logic wake_irq; // Interrupt from a running peripheral

  modport dev (output clk_g0, output clk_g1, output run0, output run1, input wake_irq);
  modport per (input clk_g0, input clk_g1, input run0, input run1, output wake_irq);
endinterface

/* File: rtl/pcgc_periph_end.sv */
// Peripheral side: interrupt collection and access qualification
`include "pcgc_params.svh"

module pcgc_periph_end
  import pcgc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  pcgc_if.per link,
  input wire logic [15:0] irq0,
  input wire logic [15:0] irq1,
  input wire logic acc_valid,
  input wire logic [4:0] acc_sel,
  output logic acc_taken,
  output logic acc_ignored,
  output logic [15:0] periph_disable0,
  output logic [15:0] periph_disable1
);
  // ==========================================================
  // Wake request
  // Only a peripheral whose clock runs can raise an interrupt at all
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link.wake_irq <= 1'b0;
    end else begin
      link.wake_irq <= |({irq1, irq0} & {link.run1, link.run0});
    end
  end

  // ==========================================================
  // Access qualification
  logic sel_running; // Addressed peripheral has a clock
  always_comb begin
    sel_running = acc_sel[4] ? link.run1[acc_sel[3:0]] : link.run0[acc_sel[3:0]];
  end

  // (RULE9) gated access dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_taken <= 1'b0;
      acc_ignored <= 1'b0;
    end else begin
      acc_taken <= acc_valid & sel_running;
      acc_ignored <= acc_valid & ~sel_running;
    end
  end

  // ==========================================================
  // (RULE10) disable while gated
  // (RULE16) disable before stop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      periph_disable0 <= 16'hFFFF;
      periph_disable1 <= 16'hFFFF;
    end else begin
      periph_disable0 <= ~link.run0;
      periph_disable1 <= ~link.run1;
    end
  end
endmodule

/* File: rtl/pcgc_device.sv */
// Peripheral clock control: registers, rate muxes, clock gates, stop mode
//
// Overview of operation
// (RULE1) Default peripheral clock is system clock rate
// (RULE2) Triple rate only when PLL drives system
// (RULE3) Bit 14 selects timer group rate
// (RULE4) Bit 13 selects modulator rate
// (RULE5) Bit 12 selects two-wire run clock rate
// (RULE6) Software writes zero to reserved bits
// (RULE7) Software disables peripheral before reclocking it
// (RULE8) Cleared enable: no clock, peripheral stopped
// (RULE9) Accesses to gated peripheral have no effect
// (RULE10) Software disables peripheral while clock gated
// (RULE11) Stop gates enabled clocks unless kept running
// (RULE12) First enable register gates nine peripherals
// (RULE13) Second enable register gates timers, channels
// (RULE14) First keep-running register mirrors first enables
// (RULE15) Running peripheral interrupt returns to Run mode
// (RULE16) Software disables non-kept peripherals before Stop
// (RULE17) Keep-running only applies when enable set
// (RULE18) Second keep-running register mirrors second enables
// (RULE19) Glitch-free gates change while source low
//
// Design decision made here: register access over Avalon-MM.
`include "pcgc_params.svh"

module pcgc_device
  import pcgc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_3x,
  input wire logic pll_sys,
  input wire logic [6:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic stop_mode,
  pcgc_if.dev link
);
  // ==========================================================
  // Decode helpers

  // Source clock that feeds a given gated clock
  function automatic pcgc_src_t src_of(input int grp, input int bit_idx);
    if (grp == 0 && bit_idx == `PCGC_BIT_GRP0_PWM) begin
      return PCGC_SRC_PWM;
    end else if (grp == 0 && bit_idx == `PCGC_BIT_GRP0_I2C) begin
      return PCGC_SRC_I2C;
    end else if (grp == 1 && bit_idx <= `PCGC_BIT_GRP1_TMR_TOP) begin
      return PCGC_SRC_TMR;
    end else begin
      return PCGC_SRC_SYS;
    end
  endfunction

  // Merge a write into a register through byte lanes and a mask
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                        input logic [1:0] be, input logic [15:0] mask);
    logic [15:0] lanes;
    lanes = {{8{be[1]}}, {8{be[0]}}};
    return ((old & ~lanes) | (wd & lanes)) & mask;
  endfunction

  // ==========================================================
  // Register file
  logic [15:0] rate; // Rate select
  logic [15:0] pce0; // Clock enables, first group
  logic [15:0] pce1; // Clock enables, second group
  logic [15:0] sd0; // Keep running in Stop, first group
  logic [15:0] sd1; // Keep running in Stop, second group
  logic ack; // Second cycle of an access
  logic done; // Access completes at this edge
  logic [4:0] idx; // Word index of the access
  pcgc_mode_t mode; // Run or Stop
  pcgc_mode_t next_mode; // Mode at next edge

  assign idx = address[6:2];
  // One wait cycle so read data can come from a flop
  assign waitrequest = (read | write) & ~ack;
  assign done = (read | write) & ack;

  // Access phase tracker
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
    end else begin
      ack <= (read | write) & ~ack;
    end
  end

  // Register writes; reserved bits are masked to zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rate <= `PCGC_RST_REG;
      pce0 <= `PCGC_RST_REG;
      pce1 <= `PCGC_RST_REG;
      sd0 <= `PCGC_RST_REG;
      sd1 <= `PCGC_RST_REG;
    end else if (write && done) begin
      case (idx)
        // (RULE3) timer rate bit
        // (RULE4) modulator rate bit
        // (RULE5) two-wire rate bit
        `PCGC_IDX_RATE: begin
          rate <= merge(rate, writedata[15:0], byteenable[1:0], `PCGC_MASK_RATE);
        end
        // (RULE12) first enable bits
        `PCGC_IDX_PCE0: begin
          pce0 <= merge(pce0, writedata[15:0], byteenable[1:0], `PCGC_MASK_GRP0);
        end
        // (RULE13) second enable bits
        `PCGC_IDX_PCE1: begin
          pce1 <= merge(pce1, writedata[15:0], byteenable[1:0], `PCGC_MASK_GRP1);
        end
        // (RULE14) first keep-running bits
        `PCGC_IDX_SD0: begin
          sd0 <= merge(sd0, writedata[15:0], byteenable[1:0], `PCGC_MASK_GRP0);
        end
        // (RULE18) second keep-running bits
        `PCGC_IDX_SD1: begin
          sd1 <= merge(sd1, writedata[15:0], byteenable[1:0], `PCGC_MASK_GRP1);
        end
        // Other offsets store nothing
        default: begin
        end
      endcase
    end
  end

  // Read data, captured in the wait cycle; unmapped reads give zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readdata <= 32'h0000_0000;
    end else if (read && !ack) begin
      case (idx)
        `PCGC_IDX_RATE: readdata <= {16'h0000, rate};
        `PCGC_IDX_PCE0: readdata <= {16'h0000, pce0};
        `PCGC_IDX_PCE1: readdata <= {16'h0000, pce1};
        `PCGC_IDX_SD0: readdata <= {16'h0000, sd0};
        `PCGC_IDX_SD1: readdata <= {16'h0000, sd1};
        `PCGC_IDX_STAT: begin
          readdata <= 32'h0000_0000;
          readdata[`PCGC_BIT_STAT_STOP] <= (mode == PCGC_STOP);
          readdata[`PCGC_BIT_STAT_PLL] <= pll_sys;
        end
        default: readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Stop mode
  logic wake_s1; // First sync stage
  logic wake_s2; // Second sync stage
  logic wake_s3; // Third sync stage
  logic wake; // Agreed wake level
  logic stop_cmd; // Software asks for Stop

  // Interrupt comes from peripheral clock domains, so it is synchronised
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_s1 <= 1'b0;
      wake_s2 <= 1'b0;
      wake_s3 <= 1'b0;
    end else begin
      wake_s1 <= link.wake_irq;
      wake_s2 <= wake_s1;
      wake_s3 <= wake_s2;
    end
  end
  assign wake = wake_s2 & wake_s3;
  assign stop_cmd = write && done && (idx == `PCGC_IDX_CTRL) && byteenable[0] &&
                    writedata[`PCGC_BIT_CTRL_STOP];

  // Next mode
  always_comb begin
    next_mode = mode;
    case (mode)
      PCGC_RUN: begin
        if (stop_cmd) begin
          next_mode = PCGC_STOP;
        end
      end
      // (RULE15) interrupt wakes to Run
      PCGC_STOP: begin
        if (wake) begin
          next_mode = PCGC_RUN;
        end
      end
      default: next_mode = PCGC_RUN;
    endcase
  end

  // Mode register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= PCGC_RUN;
    end else begin
      mode <= next_mode;
    end
  end
  assign stop_mode = (mode == PCGC_STOP);

  // ==========================================================
  // Effective enables, registered toward the peripherals
  logic [31:0] eff_en; // Clock wanted now
  always_comb begin
    // (RULE8) cleared enable stops clock
    // (RULE11) Stop gates clock
    // (RULE17) keep-running needs enable
    eff_en = {pce1, pce0} & ({32{mode == PCGC_RUN}} | {sd1, sd0});
  end

  // (RULE9) run level qualifies access
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link.run0 <= 16'h0000;
      link.run1 <= 16'h0000;
    end else begin
      link.run0 <= eff_en[15:0];
      link.run1 <= eff_en[31:16];
    end
  end

  // ==========================================================
  // Rate clocks: glitch-free mux between system and triple clock
  logic [3:0] rclk; // Source clocks indexed by pcgc_src_t
  logic [2:0] fast_sel; // Triple rate wanted, per group
  // (RULE1) zero means system rate
  // (RULE2) triple only with PLL
  assign fast_sel = {rate[`PCGC_BIT_I2C_RATE], rate[`PCGC_BIT_PWM_RATE],
                     rate[`PCGC_BIT_TMR_RATE]} & {3{pll_sys}};
  assign rclk[0] = clk;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_rate
      logic sys_on; // System clock passes
      logic fast_a; // Fast side first stage
      logic fast_on; // Fast clock passes
      logic fb_s1; // Fast state seen on system side
      logic fb_s2; // Second stage of that
      // Return path of the fast side into the system domain
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          fb_s1 <= 1'b0;
          fb_s2 <= 1'b0;
        end else begin
          fb_s1 <= fast_on;
          fb_s2 <= fb_s1;
        end
      end
      // (RULE19) system leg switches low
      always_ff @(negedge clk or negedge rst_n) begin
        if (!rst_n) begin
          sys_on <= 1'b1;
        end else begin
          sys_on <= ~fast_sel[g] & ~fb_s2;
        end
      end
      // Fast leg opens only after system leg has closed
      always_ff @(posedge clk_3x or negedge rst_n) begin
        if (!rst_n) begin
          fast_a <= 1'b0;
        end else begin
          fast_a <= fast_sel[g] & ~sys_on;
        end
      end
      // (RULE19) fast leg switches low
      always_ff @(negedge clk_3x or negedge rst_n) begin
        if (!rst_n) begin
          fast_on <= 1'b0;
        end else begin
          fast_on <= fast_a;
        end
      end
      assign rclk[g + 1] = (clk & sys_on) | (clk_3x & fast_on);
    end
  endgenerate

  // ==========================================================
  // Per-peripheral clock gates; enables change only with the source low.
  // The enable crosses into fast sources unsynchronised: software must
  // quiesce the peripheral before reclocking it, so a late gate is harmless.
  logic [31:0] gate_on; // Gate state per clock
  logic [31:0] gclk; // Gated clocks
  genvar k;
  generate
    for (k = 0; k < 32; k++) begin : g_gate
      localparam pcgc_src_t SRC = src_of(k / 16, k % 16);
      // (RULE19) gate changes while low
      always_ff @(negedge rclk[SRC] or negedge rst_n) begin
        if (!rst_n) begin
          gate_on[k] <= 1'b0;
        end else begin
          gate_on[k] <= eff_en[k];
        end
      end
      assign gclk[k] = rclk[SRC] & gate_on[k];
    end
  endgenerate
  assign link.clk_g0 = gclk[15:0];
  assign link.clk_g1 = gclk[31:16];
endmodule

/* File: dv/pcgc_checker.sv */
// Concurrent checks on the link between the clock control and its peripherals
`include "pcgc_params.svh"
module pcgc_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] clk_g0,
  input wire logic [15:0] clk_g1,
  input wire logic [15:0] run0,
  input wire logic [15:0] run1,
  input wire logic wake_irq
);
  // ==========================================================
  // Falling edge: a system-rate gated clock then shows its gate level
  default clocking cb @(negedge clk);
  endclocking
  default disable iff (!rst_n);
  // Modulator wanted off for three falls; rate mux may be mid-switch
  sequence s_pwm_idle;
    !run0[0] [*3];
  endsequence
  property p_run0_rsvd;
    (run0 & ~`PCGC_MASK_GRP0) == 16'h0000;
  endproperty
  property p_run1_rsvd;
    (run1 & ~`PCGC_MASK_GRP1) == 16'h0000;
  endproperty
  property p_clk_rsvd;
    ((clk_g0 & ~`PCGC_MASK_GRP0) | (clk_g1 & ~`PCGC_MASK_GRP1)) == 16'h0000;
  endproperty
  property p_g0_off;
    (clk_g0 & 16'hF414 & ~run0 & ~$past(run0)) == 16'h0000;
  endproperty
  property p_g0_on;
    (~clk_g0 & 16'hF414 & run0 & $past(run0)) == 16'h0000;
  endproperty
  property p_g1_off;
    (clk_g1 & 16'h7000 & ~run1 & ~$past(run1)) == 16'h0000;
  endproperty
  property p_g1_on;
    (~clk_g1 & 16'h7000 & run1 & $past(run1)) == 16'h0000;
  endproperty
  property p_pwm_off;
    s_pwm_idle |-> !clk_g0[0];
  endproperty
  // A wake request needs a peripheral whose clock was running
  property p_wake;
    wake_irq |-> (($past(run0) | $past(run1)) != 16'h0000);
  endproperty
  a_run0_rsvd: assert property (p_run0_rsvd) else $error("run0 reserved bit set");
  a_run1_rsvd: assert property (p_run1_rsvd) else $error("run1 reserved bit set");
  a_clk_rsvd: assert property (p_clk_rsvd) else $error("reserved clock toggles");
  a_g0_off: assert property (p_g0_off) else $error("group0 clock runs while off");
  a_g0_on: assert property (p_g0_on) else $error("group0 clock missing");
  a_g1_off: assert property (p_g1_off) else $error("group1 clock runs while off");
  a_g1_on: assert property (p_g1_on) else $error("group1 clock missing");
  a_pwm_off: assert property (p_pwm_off) else $error("modulator clock leaks");
  a_wake: assert property (p_wake) else $error("wake without running clock");
endmodule

/* File: dv/peripheral_clock_gating_control_tb.sv */
// Self-checking bench for both ends of the peripheral clock control
`include "pcgc_params.svh"
module peripheral_clock_gating_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Stimulus and observed signals
  logic clk = 1'b0;
  logic clk_3x = 1'b0;
  logic rst_n = 1'b0;
  logic pll_sys = 1'b1;
  logic [6:0] address = 7'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] readdata;
  logic waitrequest;
  logic stop_mode;
  logic [15:0] irq0 = 16'h0000;
  logic [15:0] irq1 = 16'h0000;
  logic acc_valid = 1'b0;
  logic [4:0] acc_sel = 5'h00;
  logic acc_taken;
  logic acc_ignored;
  logic [15:0] periph_disable0;
  logic [15:0] periph_disable1;
  int seed = 65;
  int bad_count = 0;
  int comparisons = 0;
  int e0, e1, e2;
  int rv; // Random write value; kept apart from the edge counters, which run on
  logic [31:0] rd_q[$]; // Expected read data, oldest first
  logic [1:0] acc_q[$]; // Expected {taken, ignored}
  logic [15:0] msk [5] = '{`PCGC_MASK_RATE, `PCGC_MASK_GRP0, `PCGC_MASK_GRP1, `PCGC_MASK_GRP0, `PCGC_MASK_GRP1};
  logic [15:0] rates [4] = '{16'h0000, 16'h7000, 16'h2000, 16'h5000};
  logic plls [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
  pcgc_if lnk();
  pcgc_device pcgc_device_inst (.clk(clk), .rst_n(rst_n), .clk_3x(clk_3x), .pll_sys(pll_sys),
    .address(address), .read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .stop_mode(stop_mode), .link(lnk));
  pcgc_periph_end pcgc_periph_end_inst (.clk(clk), .rst_n(rst_n), .link(lnk), .irq0(irq0), .irq1(irq1),
    .acc_valid(acc_valid), .acc_sel(acc_sel), .acc_taken(acc_taken), .acc_ignored(acc_ignored),
    .periph_disable0(periph_disable0), .periph_disable1(periph_disable1));
  pcgc_checker pcgc_checker_inst (.clk(clk), .rst_n(rst_n), .clk_g0(lnk.clk_g0), .clk_g1(lnk.clk_g1),
    .run0(lnk.run0), .run1(lnk.run1), .wake_irq(lnk.wake_irq));
  // ==========================================================
  // Clocks: the triple rate is free-running and unrelated in phase
  always #10 clk = ~clk;
  always #3.333 clk_3x = ~clk_3x;
  // Gated clock edge counters
  always @(posedge lnk.clk_g0[0]) e0++;
  always @(posedge lnk.clk_g0[6]) e1++;
  always @(posedge lnk.clk_g1[0]) e2++;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Avalon cycle: hold everything until waitrequest is seen low at a falling edge, then drop at the next rising edge
  task automatic bus(input logic wr, input logic [4:0] idx, input logic [15:0] data, input logic [3:0] be);
    int n;
    @(posedge clk);
    address <= {idx, 2'b00};
    write <= wr;
    read <= !wr;
    writedata <= {16'h0000, data};
    byteenable <= be;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      bad_count++;
      conclude();
    end
    @(posedge clk);
    write <= 1'b0;
    read <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] idx, input logic [31:0] exp);
    rd_q.push_back(exp);
    bus(1'b0, idx, 16'h0000, 4'hF);
  endtask
  task automatic acc(input logic [4:0] sel, input logic [1:0] exp);
    acc_q.push_back(exp);
    @(posedge clk);
    acc_valid <= 1'b1;
    acc_sel <= sel;
    @(posedge clk);
    acc_valid <= 1'b0;
  endtask
  // Bounded wait for the mode output to reach a level
  task automatic wait_mode(input logic lvl);
    int n;
    n = 0;
    while (stop_mode !== lvl && n < 60) begin
      @(negedge clk);
      n++;
    end
    if (n >= 60) begin
      bad_count++;
      conclude();
    end
  endtask
  // ==========================================================
  // Result watcher: each result takes the oldest note
  always @(negedge clk) begin
    if (read && waitrequest === 1'b0) check("readdata", readdata, rd_q.size() ? rd_q.pop_front() : 32'hX);
    if (acc_taken | acc_ignored) check("access", {30'h0, acc_taken, acc_ignored}, acc_q.size() ? {30'h0, acc_q.pop_front()} : 32'hX);
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    check("disable0", {16'h0000, periph_disable0}, 32'h0000FFFF);
    for (int i = 11; i <= 15; i++) rd(i[4:0], 32'h0);
    rd(5'h05, 32'h0);
    rd(5'h12, 32'h0);
    $display("test reset values done");
    for (int i = 0; i < 10; i++) begin
      rv = $random(seed);
      bus(1'b1, 5'h0B + i % 5, rv[15:0], 4'hF);
      rd(5'h0B + i % 5, {16'h0000, rv[15:0] & msk[i % 5]});
    end
    bus(1'b1, `PCGC_IDX_PCE0, 16'h0000, 4'hF);
    bus(1'b1, `PCGC_IDX_PCE0, 16'hFFFF, 4'h2);
    rd(`PCGC_IDX_PCE0, 32'h0000F400);
    $display("test register access done");
    bus(1'b1, `PCGC_IDX_RATE, 16'h0000, 4'hF);
    bus(1'b1, `PCGC_IDX_PCE0, 16'h0001, 4'hF);
    bus(1'b1, `PCGC_IDX_PCE1, 16'h0000, 4'hF);
    repeat (3) @(posedge clk);
    acc(5'h00, 2'b10);
    acc(5'h02, 2'b01);
    check("disable0", {16'h0000, periph_disable0}, 32'h0000FFFE);
    $display("test gating done");
    bus(1'b1, `PCGC_IDX_PCE0, 16'h0005, 4'hF);
    bus(1'b1, `PCGC_IDX_SD0, 16'h0014, 4'hF);
    bus(1'b1, `PCGC_IDX_PCE1, 16'h1001, 4'hF);
    bus(1'b1, `PCGC_IDX_SD1, 16'h1000, 4'hF);
    bus(1'b1, `PCGC_IDX_CTRL, 16'h0001, 4'hF);
    wait_mode(1'b1);
    @(posedge clk);
    rd(`PCGC_IDX_STAT, {30'h0, pll_sys, 1'b1});
    repeat (3) @(posedge clk);
    acc(5'h00, 2'b01);
    acc(5'h02, 2'b10);
    acc(5'h04, 2'b01);
    acc(5'h1C, 2'b10);
    acc(5'h10, 2'b01);
    irq0 <= 16'h0001;
    repeat (12) @(posedge clk);
    check("stop held", {31'h0, stop_mode}, 32'h1);
    irq0 <= 16'h0004;
    wait_mode(1'b0);
    @(posedge clk);
    irq0 <= 16'h0000;
    rd(`PCGC_IDX_STAT, {30'h0, pll_sys, 1'b0});
    $display("test stop and wake done");
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, `PCGC_IDX_PCE0, 16'h0000, 4'hF);
      bus(1'b1, `PCGC_IDX_PCE1, 16'h0000, 4'hF);
      pll_sys <= plls[k];
      bus(1'b1, `PCGC_IDX_RATE, rates[k], 4'hF);
      bus(1'b1, `PCGC_IDX_PCE0, 16'h0041, 4'hF);
      bus(1'b1, `PCGC_IDX_PCE1, 16'h0001, 4'hF);
      repeat (20) @(posedge clk);
      e0 = 0;
      e1 = 0;
      e2 = 0;
      repeat (20) @(posedge clk);
      check("pwm edges", e0 / 2 + 1 - ((plls[k] && rates[k][13]) ? 30 : 10), 32'h1);
      check("i2c edges", e1 / 2 + 1 - ((plls[k] && rates[k][12]) ? 30 : 10), 32'h1);
      check("timer edges", e2 / 2 + 1 - ((plls[k] && rates[k][14]) ? 30 : 10), 32'h1);
    end
    $display("test clock rates done");
    check("pending", rd_q.size() + acc_q.size(), 32'h0);
    conclude();
  end
endmodule
